/* File: logic/tcc_pkg.sv */
// What this block does
// - three comparators, own setup, shared status
// - comparator runs only while enable bit set
// - pin enable drives result pin, else internal
// - result pin carries unsynchronised comparator result
// - result high when plus exceeds minus; invertible
// - edge select: any, falling, rising, none
// - event sets flag, blocks triggers until cleared
// - first event after enabling events takes any edge
// - plus input: reference or pin A
// - minus input: pin B, C, D or bandgap
// - status mirrors flags 10:8, results 2:0
// - idle stop bit halts all comparators in idle
// - unimplemented bits read as zero
// - reference select: pin reference or ladder output
// - bandgap source: full, half, pin; 11 also pin
// - ladder power bit
// - ladder output pin connect bit
// - ladder supply: reference pins or analog rails
// - five-bit ladder level, level/32 of span
`default_nettype none
package tcc_pkg;
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFS_SETUP_ONE = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_SETUP_TWO = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_SETUP_THREE = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_GROUP_STATUS = 12'h00C;
  localparam logic [ADDR_W-1:0] OFS_LADDER_SETUP = 12'h010;
  localparam int NUM_CMP = 3;
  localparam logic [15:0] SETUP_WMASK = 16'hE2D3;
  localparam logic [15:0] LADDER_WMASK = 16'h07FF;
  localparam int STATUS_IDLE_BIT = 15;
  localparam int STATUS_FLAG_LSB = 8;
  localparam int STATUS_RESULT_LSB = 0;
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_ANY = 2'h3;
  localparam logic [15:0] SETUP_RESET = 16'h0000;
  localparam logic [15:0] LADDER_RESET = 16'h0000;

  // layout equals the register word, bit 15 first
  typedef struct packed {
    logic comparator_enable;
    logic result_pin_enable;
    logic result_invert;
    logic [2:0] rsv_hi;
    logic event_flag;
    logic comparator_result;
    logic [1:0] event_edge_select;
    logic rsv_mid;
    logic plus_input_select;
    logic [1:0] rsv_lo;
    logic [1:0] minus_input_select;
  } tcc_setup_t;

  typedef struct packed {
    logic [4:0] rsv;
    logic ladder_or_pin_ref;
    logic [1:0] bandgap_source_select;
    logic ladder_power;
    logic ladder_pin_drive;
    logic ladder_supply_select;
    logic [4:0] ladder_level;
  } tcc_ladder_t;

  typedef struct packed {
    logic [NUM_CMP-1:0] comparator_power;
    logic [NUM_CMP-1:0] plus_input_select;
    logic [NUM_CMP-1:0][1:0] minus_input_select;
    logic ladder_or_pin_ref;
    logic [1:0] bandgap_source_select;
    logic ladder_power;
    logic ladder_pin_drive;
    logic ladder_supply_select;
    logic [4:0] ladder_level;
  } tcc_analog_t;

  typedef struct packed {
    logic [ADDR_W-1:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } tcc_apb_req_t;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } tcc_apb_rsp_t;

  typedef struct packed {
    tcc_setup_t [NUM_CMP-1:0] setup;
    logic idle_stop_all;
    tcc_ladder_t ladder;
    logic [NUM_CMP-1:0] sync_meta;
    logic [NUM_CMP-1:0] sync_res;
    logic [NUM_CMP-1:0] prev_res;
    logic [NUM_CMP-1:0] first_any;
    logic [NUM_CMP-1:0] trig;
    logic [31:0] rdata;
    logic err;
  } tcc_state_t;
endpackage : tcc_pkg
`default_nettype wire

/* File: logic/tcc_ctrl.sv */
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module tcc_ctrl (
  input wire logic clk,
  input wire logic arst_n,
  input wire tcc_pkg::tcc_apb_req_t apb_req,
  output tcc_pkg::tcc_apb_rsp_t apb_rsp,
  input wire logic [tcc_pkg::NUM_CMP-1:0] analog_raw,
  input wire logic idle_mode,
  output tcc_pkg::tcc_analog_t analog_ctrl,
  output logic [tcc_pkg::NUM_CMP-1:0] result_pin,
  output logic [tcc_pkg::NUM_CMP-1:0] result_pin_oe,
  output logic [tcc_pkg::NUM_CMP-1:0] event_trigger
);
  import tcc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // reset release
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state
  tcc_state_t st_reg;
  tcc_state_t st_next;
  logic [NUM_CMP-1:0] hit_v;
  logic [NUM_CMP-1:0] run_v;
  logic [NUM_CMP-1:0] res_v;
  logic [NUM_CMP-1:0] wr_setup_v;
  logic [15:0] status_word;
  logic [15:0] rd_word;
  logic [15:0] lane_mask;
  logic setup_phase;
  logic access_phase;
  logic hit_any_reg;

  assign setup_phase = apb_req.psel && !apb_req.penable;
  assign access_phase = apb_req.psel && apb_req.penable;
  assign lane_mask = {{8{apb_req.pstrb[1]}}, {8{apb_req.pstrb[0]}}};

  always_comb begin
    tcc_setup_t s;
    logic rise;
    logic fall;
    logic taken;
    logic [15:0] wval;
    s = '0;
    rise = 1'b0;
    fall = 1'b0;
    taken = 1'b0;
    wval = '0;
    st_next = st_reg;
    hit_v = '0;
    run_v = '0;
    res_v = '0;
    wr_setup_v = '0;
    status_word = '0;
    rd_word = '0;
    hit_any_reg = 1'b0;

    // raw analog results are asynchronous
    st_next.sync_meta = analog_raw;
    st_next.sync_res = st_reg.sync_meta;

    // shared status view
    status_word[STATUS_IDLE_BIT] = st_reg.idle_stop_all;
    for (int i = 0; i < NUM_CMP; i++) begin
      status_word[STATUS_FLAG_LSB + i] = st_reg.setup[i].event_flag;
      status_word[STATUS_RESULT_LSB + i] =
        st_reg.setup[i].comparator_result;
    end

    // address decode, unmapped reads zero with error
    unique case (apb_req.paddr)
      OFS_SETUP_ONE: rd_word = st_reg.setup[0];
      OFS_SETUP_TWO: rd_word = st_reg.setup[1];
      OFS_SETUP_THREE: rd_word = st_reg.setup[2];
      OFS_GROUP_STATUS: rd_word = status_word;
      OFS_LADDER_SETUP: rd_word = st_reg.ladder;
      default: hit_any_reg = 1'b1;
    endcase

    // read data and error captured in setup phase
    if (setup_phase) begin
      st_next.rdata = {16'h0000, rd_word};
      st_next.err = hit_any_reg;
    end

    // writes take effect in the access phase
    if (access_phase && apb_req.pwrite) begin
      unique case (apb_req.paddr)
        OFS_SETUP_ONE: wr_setup_v[0] = 1'b1;
        OFS_SETUP_TWO: wr_setup_v[1] = 1'b1;
        OFS_SETUP_THREE: wr_setup_v[2] = 1'b1;
        OFS_GROUP_STATUS: begin
          if (apb_req.pstrb[1]) begin
            st_next.idle_stop_all = apb_req.pwdata[STATUS_IDLE_BIT];
          end
        end
        OFS_LADDER_SETUP: begin
          st_next.ladder = (st_reg.ladder & ~(LADDER_WMASK & lane_mask))
            | (apb_req.pwdata[15:0] & LADDER_WMASK & lane_mask);
        end
        default: begin
        end
      endcase
    end

    for (int i = 0; i < NUM_CMP; i++) begin
      s = st_reg.setup[i];
      // running only when enabled and not idle-stopped
      run_v[i] = s.comparator_enable
        && !(st_reg.idle_stop_all && idle_mode);
      if (!s.comparator_enable) begin
        res_v[i] = 1'b0;
      end else if (run_v[i]) begin
        res_v[i] = st_reg.sync_res[i] ^ s.result_invert;
      end else begin
        res_v[i] = s.comparator_result;
      end
      rise = res_v[i] && !st_reg.prev_res[i];
      fall = !res_v[i] && st_reg.prev_res[i];
      if (run_v[i] && s.event_edge_select != EDGE_NONE) begin
        if (st_reg.first_any[i]) begin
          hit_v[i] = rise || fall;
        end else begin
          unique case (s.event_edge_select)
            EDGE_RISE: hit_v[i] = rise;
            EDGE_FALL: hit_v[i] = fall;
            EDGE_ANY: hit_v[i] = rise || fall;
            default: hit_v[i] = 1'b0;
          endcase
        end
      end
      taken = hit_v[i] && !s.event_flag;
      st_next.prev_res[i] = res_v[i];
      st_next.trig[i] = taken;

      if (wr_setup_v[i]) begin
        wval = (s & ~(SETUP_WMASK & lane_mask))
          | (apb_req.pwdata[15:0] & SETUP_WMASK & lane_mask);
        s = wval;
        if (st_reg.setup[i].event_edge_select == EDGE_NONE
            && s.event_edge_select != EDGE_NONE) begin
          st_next.first_any[i] = 1'b1;
        end
      end
      if (taken) begin
        st_next.first_any[i] = 1'b0;
      end
      s.comparator_result = res_v[i];
      // hardware set beats a software clear in the same cycle
      if (hit_v[i]) begin
        s.event_flag = 1'b1;
      end
      st_next.setup[i] = s;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '{setup: {NUM_CMP{SETUP_RESET}}, ladder: LADDER_RESET,
                  rdata: 32'h0000_0000, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign apb_rsp.pready = access_phase;
  assign apb_rsp.prdata = st_reg.rdata;
  assign apb_rsp.pslverr = access_phase && st_reg.err;
  assign event_trigger = st_reg.trig;

  always_comb begin
    for (int i = 0; i < NUM_CMP; i++) begin
      // pin path bypasses the synchroniser on purpose
      result_pin[i] = st_reg.setup[i].comparator_enable
        && (analog_raw[i] ^ st_reg.setup[i].result_invert);
      result_pin_oe[i] = st_reg.setup[i].comparator_enable
        && st_reg.setup[i].result_pin_enable;
      analog_ctrl.comparator_power[i] = run_v[i];
      analog_ctrl.plus_input_select[i] =
        st_reg.setup[i].plus_input_select;
      analog_ctrl.minus_input_select[i] =
        st_reg.setup[i].minus_input_select;
    end
    analog_ctrl.ladder_or_pin_ref = st_reg.ladder.ladder_or_pin_ref;
    analog_ctrl.bandgap_source_select =
      st_reg.ladder.bandgap_source_select;
    analog_ctrl.ladder_power = st_reg.ladder.ladder_power;
    analog_ctrl.ladder_pin_drive = st_reg.ladder.ladder_pin_drive;
    analog_ctrl.ladder_supply_select =
      st_reg.ladder.ladder_supply_select;
    analog_ctrl.ladder_level = st_reg.ladder.ladder_level;
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_apb_access;
    apb_req.psel && !apb_req.penable ##1 apb_req.psel && apb_req.penable;
  endsequence

  AST_APB_ONE_WAIT: assert property (
    s_apb_access |-> apb_rsp.pready)
    else $error("apb access not answered at once");

  AST_APB_UNMAPPED: assert property (
    (setup_phase && apb_req.paddr == 12'h014) ##1 access_phase
    |-> apb_rsp.pslverr && apb_rsp.prdata == 32'h0000_0000)
    else $error("unmapped access not flagged");

  AST_LADDER_RSV_ZERO: assert property (
    st_reg.ladder.rsv == 5'h00)
    else $error("unimplemented ladder bit set");

  AST_RDATA_HIGH_ZERO: assert property (
    apb_rsp.prdata[31:16] == 16'h0000)
    else $error("upper read data not zero");

  AST_IDLE_BIT_WRITE: assert property (
    access_phase && apb_req.pwrite && apb_req.paddr == OFS_GROUP_STATUS
      && apb_req.pstrb[1]
    |=> st_reg.idle_stop_all == $past(apb_req.pwdata[STATUS_IDLE_BIT]))
    else $error("idle stop bit not written");

  AST_LADDER_WRITE: assert property (
    access_phase && apb_req.pwrite && apb_req.paddr == OFS_LADDER_SETUP
      && apb_req.pstrb[1:0] == 2'h3
    |=> st_reg.ladder == ($past(apb_req.pwdata[15:0]) & LADDER_WMASK))
    else $error("ladder write lost");

  AST_MISS_NO_WRITE: assert property (
    access_phase && apb_req.pwrite && hit_any_reg
    |=> $stable(st_reg.ladder) && $stable(st_reg.idle_stop_all))
    else $error("unmapped write changed a register");

  for (genvar g = 0; g < NUM_CMP; g++) begin : g_chk
    sequence s_fall_seen;
      st_reg.setup[g].comparator_result ##1
        !st_reg.setup[g].comparator_result;
    endsequence

    sequence s_rise_seen;
      !st_reg.setup[g].comparator_result ##1
        st_reg.setup[g].comparator_result;
    endsequence

    // setup write while events are off
    sequence s_arm_write;
      wr_setup_v[g] && st_reg.setup[g].event_edge_select == EDGE_NONE;
    endsequence

    AST_DISABLED_ZERO: assert property (
      !st_reg.setup[g].comparator_enable |=>
        !st_reg.setup[g].comparator_result || $past(wr_setup_v[g]))
      else $error("disabled comparator shows a result");

    AST_DISABLED_NO_TRIG: assert property (
      !$past(st_reg.setup[g].comparator_enable) |-> !event_trigger[g])
      else $error("disabled comparator triggered");

    AST_PIN_OFF: assert property (
      !st_reg.setup[g].result_pin_enable |-> !result_pin_oe[g])
      else $error("result pin driven while disabled");

    AST_PIN_RAW: assert property (
      st_reg.setup[g].comparator_enable |->
        result_pin[g] == (analog_raw[g] ^ st_reg.setup[g].result_invert))
      else $error("result pin not the raw comparator value");

    AST_FLAG_SETS: assert property (
      hit_v[g] |=> st_reg.setup[g].event_flag)
      else $error("event did not set flag");

    AST_FLAG_BLOCKS: assert property (
      st_reg.setup[g].event_flag |=> !event_trigger[g])
      else $error("trigger while flag set");

    AST_FLAG_STICKY: assert property (
      st_reg.setup[g].event_flag && !wr_setup_v[g]
        |=> st_reg.setup[g].event_flag)
      else $error("flag cleared without a write");

    AST_RISE_ONLY: assert property (
      (st_reg.setup[g].event_edge_select == EDGE_RISE && !st_reg.first_any[g]
       && run_v[g]) throughout s_fall_seen |-> !event_trigger[g])
      else $error("rising mode fired on falling edge");

    AST_FALL_ONLY: assert property (
      (st_reg.setup[g].event_edge_select == EDGE_FALL && !st_reg.first_any[g]
       && run_v[g]) throughout s_rise_seen |-> !event_trigger[g])
      else $error("falling mode fired on rising edge");

    AST_IDLE_HOLD: assert property (
      st_reg.idle_stop_all && idle_mode && !wr_setup_v[g]
        && st_reg.setup[g].comparator_enable
        |=> $stable(st_reg.setup[g].comparator_result))
      else $error("stopped comparator result moved");

    AST_MIRROR: assert property (
      setup_phase && apb_req.paddr == OFS_GROUP_STATUS |=>
        apb_rsp.prdata[STATUS_FLAG_LSB + g]
          == $past(st_reg.setup[g].event_flag)
        && apb_rsp.prdata[STATUS_RESULT_LSB + g]
          == $past(st_reg.setup[g].comparator_result))
      else $error("status mirror mismatch");

    AST_SETUP_RSV_ZERO: assert property (
      st_reg.setup[g].rsv_hi == 3'h0 && !st_reg.setup[g].rsv_mid
        && st_reg.setup[g].rsv_lo == 2'h0)
      else $error("unimplemented setup bit set");

    AST_RESULT_TRACKS: assert property (
      run_v[g] |=> st_reg.setup[g].comparator_result
        == ($past(st_reg.sync_res[g])
            ^ $past(st_reg.setup[g].result_invert)))
      else $error("result does not follow the comparator");

    AST_POWER_OFF: assert property (
      !st_reg.setup[g].comparator_enable
        |-> !analog_ctrl.comparator_power[g])
      else $error("disabled comparator powered");

    AST_IDLE_POWER: assert property (
      st_reg.idle_stop_all && idle_mode
        |-> !analog_ctrl.comparator_power[g])
      else $error("idle-stopped comparator powered");

    AST_IDLE_RUN: assert property (
      st_reg.setup[g].comparator_enable && !st_reg.idle_stop_all
        |-> analog_ctrl.comparator_power[g])
      else $error("enabled comparator stopped");

    AST_IDLE_NO_TRIG: assert property (
      st_reg.idle_stop_all && idle_mode |=> !event_trigger[g])
      else $error("idle-stopped comparator triggered");

    AST_NONE_NO_TRIG: assert property (
      st_reg.setup[g].event_edge_select == EDGE_NONE |=> !event_trigger[g])
      else $error("trigger with events disabled");

    AST_TRIG_SETS_FLAG: assert property (
      event_trigger[g] |-> st_reg.setup[g].event_flag)
      else $error("trigger without event flag");

    AST_TRIG_PULSE: assert property (
      event_trigger[g] |=> !event_trigger[g])
      else $error("trigger longer than one cycle");

    AST_ARM_ANY: assert property (
      s_arm_write |=> st_reg.setup[g].event_edge_select == EDGE_NONE
        || st_reg.first_any[g])
      else $error("first event not armed for any edge");

    AST_PIN_ON: assert property (
      st_reg.setup[g].comparator_enable && st_reg.setup[g].result_pin_enable
        |-> result_pin_oe[g])
      else $error("result pin not driven");

    AST_DISABLED_PIN: assert property (
      !st_reg.setup[g].comparator_enable
        |-> !result_pin[g] && !result_pin_oe[g])
      else $error("disabled comparator drives its pin");
  end
endmodule : tcc_ctrl
`default_nettype wire

/* File: verif/tcc_far_model.sv */
`timescale 1ns/1ps
`default_nettype none
module tcc_far_model (
  input wire logic clk,
  input wire tcc_pkg::tcc_analog_t ctl,
  input wire logic [7:0] pin_v [4],
  input wire logic [7:0] vref_v,
  output logic [2:0] raw
);
  import tcc_pkg::*;
  localparam logic [7:0] BG_V = 8'h64;
  logic flip = 1'b0;
  logic [7:0] lad, pl, mi;
  logic [1:0] bs;
  // unpowered comparator output means nothing, so it wanders
  always @(posedge clk) flip <= ~flip;
  always_comb begin
    bs = ctl.bandgap_source_select;
    lad = ctl.ladder_supply_select ? vref_v : 8'hFF;
    lad = 8'((13'(ctl.ladder_level) * 13'(lad)) >> 5);
    if (!ctl.ladder_power) lad = 8'h00;
    for (int i = 0; i < NUM_CMP; i++) begin
      pl = ctl.ladder_or_pin_ref ? vref_v : lad;
      if (!ctl.plus_input_select[i]) pl = pin_v[0];
      case (ctl.minus_input_select[i])
        2'h0: mi = pin_v[1];
        2'h1: mi = pin_v[2];
        2'h2: mi = pin_v[3];
        default: mi = bs[1] ? vref_v : (bs[0] ? BG_V >> 1 : BG_V);
      endcase
      raw[i] = ctl.comparator_power[i] ? pl > mi : flip ^ i[0];
    end
  end
endmodule : tcc_far_model
`default_nettype wire

/* File: verif/triple_comparator_ctrl_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module triple_comparator_ctrl_bench;
  import tcc_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic idle_mode = 1'b0;
  tcc_apb_req_t req = '0;
  tcc_apb_rsp_t rsp;
  tcc_analog_t actl;
  logic [2:0] raw, rpin, roe, trig;
  logic [7:0] pin_v [4] = '{default: 8'h00};
  logic [7:0] vref_v = 8'hC8;
  logic [7:0] mv, lv;
  logic [4:0] lvl;
  logic [15:0] w;
  logic [3:0] strb = 4'h3;
  logic [32:0] exp_q [$];
  int error_cnt = 0;
  int cmp_count = 0;
  int seed = 32'h3c27;
  int trig_n [3] = '{default: 0};
  always #2 clk = ~clk;
  tcc_ctrl dut_u (.clk(clk), .arst_n(arst_n), .apb_req(req), .apb_rsp(rsp),
    .analog_raw(raw), .idle_mode(idle_mode), .analog_ctrl(actl),
    .result_pin(rpin), .result_pin_oe(roe), .event_trigger(trig));
  tcc_far_model far_u (.clk(clk), .ctl(actl), .pin_v(pin_v),
    .vref_v(vref_v), .raw(raw));
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [32:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(input logic [11:0] a, input logic wr_en,
                     input logic [15:0] d);
    @(posedge clk);
    req.paddr <= a;
    req.pwrite <= wr_en;
    req.pwdata <= {16'h0000, d};
    req.pstrb <= strb;
    req.psel <= 1'b1;
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (rsp.pready !== 1'b1);
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(a, 1'b0, 16'h0000);
  endtask : rd
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    apb(a, 1'b1, d);
  endtask : wr
  task automatic settle;
    repeat (8) @(posedge clk);
  endtask : settle
  task automatic step(input logic [7:0] v);
    pin_v[0] <= v;
    settle();
  endtask : step
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done
  //////////////////////////////////////////////////////////////////////
  // read data and error are taken at the access edge only
  always @(posedge clk) begin
    if (req.psel && req.penable && rsp.pready === 1'b1 && !req.pwrite) begin
      chk("read", {rsp.pslverr, rsp.prdata}, exp_q.pop_front());
    end
    for (int i = 0; i < 3; i++) trig_n[i] += int'(trig[i] === 1'b1);
  end
  initial begin
    #200000;
    error_cnt++;
    test_done();
  end
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 5; i++) rd(12'(4 * i), 33'h0);
    rd(12'h014, 33'h1_0000_0000);
    for (int i = 0; i < 3; i++) begin
      wr(12'(4 * i), 16'h7DFF);
      rd(12'(4 * i), 33'h60D3);
      chk("pins", {rpin[i], roe[i]}, 2'b00);
      wr(12'(4 * i), 16'h0000);
    end
    wr(OFS_LADDER_SETUP, 16'hFFFF);
    rd(OFS_LADDER_SETUP, 33'h07FF);
    chk("ladder", 11'(actl), 11'h7FF);
    strb = 4'h2;
    wr(OFS_LADDER_SETUP, 16'h0000);
    strb = 4'h3;
    rd(OFS_LADDER_SETUP, 33'h00FF);
    wr(OFS_GROUP_STATUS, 16'hFFFF);
    rd(OFS_GROUP_STATUS, 33'h8000);
    wr(OFS_GROUP_STATUS, 16'h0000);
    strb = 4'h1;
    wr(OFS_GROUP_STATUS, 16'h8000);
    strb = 4'h3;
    rd(OFS_GROUP_STATUS, 33'h0000);
    chk("quiet", trig_n[0] + trig_n[1] + trig_n[2], 0);
    for (int k = 0; k < 6; k++) begin
      for (int n = 0; n < 4; n++) pin_v[n] <= 8'($random(seed));
      wr(OFS_LADDER_SETUP, k == 5 ? 16'h0300 : (k == 4 ? 16'h0100 : 16'h0));
      mv = k < 3 ? pin_v[k + 1] : (k == 3 ? 8'h64 : (k == 4 ? 8'h32 : vref_v));
      w = 16'h8000 | 16'(k < 3 ? k : 3);
      wr(12'(4 * (k % 3)), w);
      settle();
      rd(12'(4 * (k % 3)), {17'h0, w | 16'(pin_v[0] > mv) << 8});
      wr(12'(4 * (k % 3)), 16'h0000);
    end
    for (int k = 0; k < 2; k++) begin
      lvl = 5'($random(seed));
      pin_v[1] <= 8'($random(seed));
      w = (k ? 16'h04A0 : 16'h00C0) | 16'(lvl);
      wr(OFS_LADDER_SETUP, w);
      wr(OFS_SETUP_TWO, 16'hE010);
      settle();
      lv = k ? vref_v : 8'((13'(lvl) * 13'hFF) >> 5);
      rd(OFS_SETUP_TWO, {17'h0, 16'hE010 | 16'(lv <= pin_v[1]) << 8});
      chk("pin", {rpin[1], roe[1]}, {lv <= pin_v[1], 1'b1});
      chk("ladder", 11'(actl), w[10:0]);
    end
    wr(OFS_SETUP_TWO, 16'h0000);
    pin_v[1] <= 8'h64;
    pin_v[0] <= 8'h96;
    wr(OFS_SETUP_ONE, 16'h8000);
    settle();
    wr(OFS_SETUP_ONE, 16'h8040);
    step(8'h32);
    chk("arm", trig_n[0], 1);
    rd(OFS_GROUP_STATUS, 33'h0100);
    step(8'h96);
    step(8'h32);
    chk("blocked", trig_n[0], 1);
    wr(OFS_SETUP_ONE, 16'h8040);
    step(8'h96);
    wr(OFS_SETUP_ONE, 16'h8040);
    step(8'h32);
    chk("rise", trig_n[0], 2);
    wr(OFS_SETUP_ONE, 16'h8080);
    step(8'h96);
    step(8'h32);
    chk("fall", trig_n[0], 3);
    wr(OFS_SETUP_ONE, 16'h80C0);
    step(8'h96);
    chk("any", trig_n[0], 4);
    rd(OFS_GROUP_STATUS, 33'h0101);
    wr(OFS_GROUP_STATUS, 16'h8000);
    idle_mode <= 1'b1;
    @(negedge clk);
    chk("idle stop", actl.comparator_power, 3'b000);
    wr(OFS_GROUP_STATUS, 16'h0000);
    @(negedge clk);
    chk("idle run", actl.comparator_power, 3'b001);
    settle();
    test_done();
  end
endmodule : triple_comparator_ctrl_bench
`default_nettype wire
